//--- hdl/sc_ctrl_pkg.sv
/*
  constants for the low select code control block: register map, command word layout, instruction codes,
  status bit positions and reset values.
  assumes one AHB-Lite bus with 32-bit data and a single clock hclk.
*/
// Summary of operation
// - set flag at code 00 enables type three
// - clear flag at code 00 disables type three
// - flag-set test at 00 skips when enabled
// - flag-clear test at 00 skips when disabled
// - set control at 05 enables parity interrupts
// - clear control at 05 disables parity interrupts
// - flag at 05 selects even sense, tests
// - flag-clear test at 05 skips when odd
// - flag-set test at 04 skips if power good
// - flag-clear test at 04 skips on power fail
// - set control at 07 enables protect; clear ignored
// - output to code 2, value 1-7: diagnose
package sc_ctrl_pkg;
	// -----------------------------------------------
	// register map (byte addresses)
	// -----------------------------------------------
	localparam logic [7:0] cmd_addr = 8'h00;
	localparam logic [7:0] status_addr = 8'h04;
	localparam logic [7:0] global_addr = 8'h08;
	// -----------------------------------------------
	// command word layout
	// -----------------------------------------------
	localparam int op_lsb = 0;
	localparam int op_width = 4;
	localparam int sc_lsb = 8;
	localparam int sc_width = 3;
	localparam int acc_lsb = 16;
	localparam int acc_width = 16;
	// instruction codes
	localparam logic [3:0] op_none = 4'h0;
	localparam logic [3:0] set_control_instr = 4'h1;
	localparam logic [3:0] clear_control_instr = 4'h2;
	localparam logic [3:0] set_flag_instr = 4'h3;
	localparam logic [3:0] clear_flag_instr = 4'h4;
	localparam logic [3:0] skip_if_flag_set_instr = 4'h5;
	localparam logic [3:0] skip_if_flag_clear_instr = 4'h6;
	localparam logic [3:0] accumulator_output_instr = 4'h7;
	// select codes handled here
	localparam logic [2:0] sc_type3 = 3'h0;
	localparam logic [2:0] sc_global = 3'h2;
	localparam logic [2:0] sc_power = 3'h4;
	localparam logic [2:0] sc_parity = 3'h5;
	localparam logic [2:0] sc_protect = 3'h7;
	// diagnose values span this range of the accumulator
	localparam logic [15:0] diag_lo = 16'h0001;
	localparam logic [15:0] diag_hi = 16'h0007;
	// -----------------------------------------------
	// status bit positions
	// -----------------------------------------------
	localparam int st_type3 = 0;
	localparam int st_parity_int = 1;
	localparam int st_parity_even = 2;
	localparam int st_protect = 3;
	localparam int st_diag = 4;
	localparam int st_diag_code = 5;
	localparam int st_skip = 8;
	localparam int st_power_ok = 9;
	// -----------------------------------------------
	// reset values
	// -----------------------------------------------
	localparam logic rst_type3 = 1'b0;
	localparam logic rst_parity_int = 1'b0;
	localparam logic rst_parity_even = 1'b0;
	localparam logic rst_protect = 1'b0;
	localparam logic [15:0] rst_global = 16'h0000;
	localparam int sync_stages = 2;
endpackage

//--- hdl/level_sync.sv
/*
  two flip-flop synchroniser for one level from outside the hclk domain.
  assumes the level is held long enough to be seen by at least one hclk edge.
*/
`timescale 1ns/100ps
`default_nettype none
module level_sync
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic meta;
	logic next_meta;
	logic next_sync_out;
	// first stage is read only by the second
	always_comb
	begin
		next_meta = async_in;
		next_sync_out = meta;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			meta <= next_meta;
			sync_out <= next_sync_out;
		end
	end
endmodule
`default_nettype wire

//--- hdl/sc_ctrl.sv
/*
  low select code control: software writes an instruction word (operation, select code, accumulator) to the
  command register; the block keeps the interrupt enables, parity sense, protect enable, diagnose mode and the
  result of the last skip test.
  assumes an AHB-Lite master on hclk, a power fail pin from outside the clock domain, and interrupt request and
  parity detect levels from logic on hclk.
*/
`timescale 1ns/100ps
`default_nettype none
module sc_ctrl
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic power_fail_pin,
	input wire logic type3_irq_req,
	input wire logic parity_err_det,
	output logic type3_irq_grant,
	output logic parity_irq,
	output logic parity_even_sense,
	output logic mem_protect_en,
	output logic diag_mode,
	output logic [2:0] diag_code,
	output logic skip_next
);
	import sc_ctrl_pkg::*;

	// -----------------------------------------------
	// bus slave
	// -----------------------------------------------
	logic wr_pend;
	logic [7:0] wr_addr;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic addr_phase;
	logic power_fail;
	logic type3_en;
	logic parity_int_en;
	logic skip_taken;
	logic [15:0] global_reg;
	logic [31:0] status_word;

	level_sync u_pf_sync
	(
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(power_fail_pin),
		.sync_out(power_fail)
	);

	// any access size; hsize is not decoded, so other sizes are answered and treated the same as words
	assign addr_phase = hsel && htrans[1] && hready;

	// status view of the block's own state
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[st_type3] = type3_en;
		status_word[st_parity_int] = parity_int_en;
		status_word[st_parity_even] = parity_even_sense;
		status_word[st_protect] = mem_protect_en;
		status_word[st_diag] = diag_mode;
		status_word[st_diag_code +: 3] = diag_code;
		status_word[st_skip] = skip_taken;
		status_word[st_power_ok] = !power_fail;
	end

	// read data is fetched in the address phase so it stands through the data phase
	always_comb
	begin
		next_wr_pend = addr_phase && hwrite;
		next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
		next_hrdata = hrdata;
		if (addr_phase && !hwrite)
		begin
			unique case (haddr[7:0])
				status_addr: next_hrdata = status_word;
				global_addr: next_hrdata = {16'h0000, global_reg};
				default: next_hrdata = 32'h0000_0000; // command and unmapped read zero
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1; // zero wait states, always OKAY
			hresp <= 1'b0;
		end
	end

	// -----------------------------------------------
	// instruction execution
	// -----------------------------------------------
	logic exec;
	logic [3:0] cmd_op;
	logic [2:0] cmd_sc;
	logic [15:0] cmd_acc;
	logic next_type3_en;
	logic next_parity_int_en;
	logic next_parity_even;
	logic next_protect;
	logic next_diag_mode;
	logic [2:0] next_diag_code;
	logic [15:0] next_global;
	logic next_skip_taken;
	logic next_skip_next;
	logic next_type3_grant;
	logic next_parity_irq;

	function automatic logic is_op(input logic [3:0] op, input logic [2:0] sc, input logic [3:0] want_op,
		input logic [2:0] want_sc);
		is_op = (op == want_op) && (sc == want_sc);
	endfunction

	assign exec = wr_pend && (wr_addr == cmd_addr);
	assign cmd_op = hwdata[op_lsb +: op_width];
	assign cmd_sc = hwdata[sc_lsb +: sc_width];
	assign cmd_acc = hwdata[acc_lsb +: acc_width];

	// one instruction per command write; codes not listed behave as no-operation
	always_comb
	begin
		next_type3_en = type3_en;
		next_parity_int_en = parity_int_en;
		next_parity_even = parity_even_sense;
		next_protect = mem_protect_en;
		next_diag_mode = diag_mode;
		next_diag_code = diag_code;
		next_global = global_reg;
		next_skip_taken = skip_taken;
		next_skip_next = 1'b0;
		if (exec)
		begin
			if (is_op(cmd_op, cmd_sc, set_flag_instr, sc_type3))
				next_type3_en = 1'b1;
			if (is_op(cmd_op, cmd_sc, clear_flag_instr, sc_type3))
				next_type3_en = 1'b0;
			if (is_op(cmd_op, cmd_sc, set_control_instr, sc_parity))
				next_parity_int_en = 1'b1;
			if (is_op(cmd_op, cmd_sc, clear_control_instr, sc_parity))
				next_parity_int_en = 1'b0;
			if (is_op(cmd_op, cmd_sc, set_flag_instr, sc_parity))
				next_parity_even = 1'b1;
			if (is_op(cmd_op, cmd_sc, clear_flag_instr, sc_parity))
				next_parity_even = 1'b0;
			// clear control at this code deliberately leaves protect on
			if (is_op(cmd_op, cmd_sc, set_control_instr, sc_protect))
				next_protect = 1'b1;
			if (is_op(cmd_op, cmd_sc, accumulator_output_instr, sc_global))
			begin
				if (cmd_acc >= diag_lo && cmd_acc <= diag_hi)
				begin
					next_diag_mode = 1'b1;
					next_diag_code = cmd_acc[2:0];
				end
				else
					next_global = cmd_acc;
			end
			// clear control at code 00 is the system reset of this state
			if (is_op(cmd_op, cmd_sc, clear_control_instr, sc_type3))
			begin
				next_type3_en = rst_type3;
				next_parity_int_en = rst_parity_int;
				next_parity_even = rst_parity_even;
				next_protect = rst_protect;
				next_diag_mode = 1'b0;
				next_diag_code = 3'h0;
				next_global = rst_global;
			end
			if (cmd_op == skip_if_flag_set_instr || cmd_op == skip_if_flag_clear_instr)
			begin
				next_skip_taken = 1'b0;
				unique case (cmd_sc)
					sc_type3: next_skip_taken = (cmd_op == skip_if_flag_set_instr) ? type3_en : !type3_en;
					sc_power: next_skip_taken = (cmd_op == skip_if_flag_set_instr) ? !power_fail : power_fail;
					sc_parity: next_skip_taken = (cmd_op == skip_if_flag_set_instr) ? parity_even_sense : !parity_even_sense;
					default: next_skip_taken = 1'b0; // other codes never skip
				endcase
				next_skip_next = next_skip_taken;
			end
		end
	end

	// grants follow the enables; a disabled class is simply not passed on
	always_comb
	begin
		next_type3_grant = type3_irq_req && next_type3_en;
		next_parity_irq = parity_err_det && next_parity_int_en;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			type3_en <= rst_type3;
			parity_int_en <= rst_parity_int;
			parity_even_sense <= rst_parity_even;
			mem_protect_en <= rst_protect;
			diag_mode <= 1'b0;
			diag_code <= 3'h0;
			global_reg <= rst_global;
			skip_taken <= 1'b0;
			skip_next <= 1'b0;
			type3_irq_grant <= 1'b0;
			parity_irq <= 1'b0;
		end
		else
		begin
			type3_en <= next_type3_en;
			parity_int_en <= next_parity_int_en;
			parity_even_sense <= next_parity_even;
			mem_protect_en <= next_protect;
			diag_mode <= next_diag_mode;
			diag_code <= next_diag_code;
			global_reg <= next_global;
			skip_taken <= next_skip_taken;
			skip_next <= next_skip_next;
			type3_irq_grant <= next_type3_grant;
			parity_irq <= next_parity_irq;
		end
	end

	// -----------------------------------------------
	// assertions
	// -----------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_type3_enable: assert property (exec && is_op(cmd_op, cmd_sc, set_flag_instr, sc_type3) |=> type3_en)
		else $error("type three not enabled");
	a_type3_disable: assert property (exec && is_op(cmd_op, cmd_sc, clear_flag_instr, sc_type3)
		|=> !type3_en && !type3_irq_grant)
		else $error("type three still granted");
	a_type3_grant_on: assert property (type3_en && type3_irq_req && !(exec && cmd_sc == sc_type3)
		|=> type3_irq_grant)
		else $error("enabled type three not granted");
	a_type3_skip_set: assert property (exec && cmd_op == skip_if_flag_set_instr && cmd_sc == sc_type3
		|=> skip_next == $past(type3_en))
		else $error("skip on type three set wrong");
	a_type3_skip_clr: assert property (exec && cmd_op == skip_if_flag_clear_instr && cmd_sc == sc_type3
		|=> skip_next == !$past(type3_en))
		else $error("skip on type three clear wrong");
	a_parity_int_on: assert property (exec && is_op(cmd_op, cmd_sc, set_control_instr, sc_parity)
		|=> parity_int_en)
		else $error("parity interrupt not enabled");
	a_parity_irq_on: assert property (parity_int_en && parity_err_det
		&& !(exec && (cmd_sc == sc_parity || cmd_sc == sc_type3)) |=> parity_irq)
		else $error("enabled parity error not raised");
	a_parity_int_off: assert property (!parity_int_en && !(exec && cmd_sc == sc_parity) |=> !parity_irq)
		else $error("parity interrupt while disabled");
	a_parity_sense: assert property (exec && cmd_op == skip_if_flag_set_instr && cmd_sc == sc_parity
		|=> skip_next == $past(parity_even_sense))
		else $error("even sense test wrong");
	a_parity_odd_skip: assert property (exec && cmd_op == skip_if_flag_clear_instr && cmd_sc == sc_parity
		|=> skip_next == !$past(parity_even_sense))
		else $error("odd sense test wrong");
	a_power_skip_set: assert property (exec && cmd_op == skip_if_flag_set_instr && cmd_sc == sc_power
		|=> skip_next != $past(power_fail))
		else $error("power good test wrong");
	a_power_skip_clr: assert property (exec && cmd_op == skip_if_flag_clear_instr && cmd_sc == sc_power
		|=> skip_next == $past(power_fail))
		else $error("power fail test wrong");
	a_protect_sticky: assert property (mem_protect_en
		&& !(exec && is_op(cmd_op, cmd_sc, clear_control_instr, sc_type3)) |=> mem_protect_en)
		else $error("protect dropped");
	a_diag_entry: assert property (exec && is_op(cmd_op, cmd_sc, accumulator_output_instr, sc_global)
		&& cmd_acc >= diag_lo && cmd_acc <= diag_hi |=> diag_mode && diag_code == $past(cmd_acc[2:0])
		&& $stable(global_reg))
		else $error("diagnose mode not entered");
	a_global_load: assert property (exec && is_op(cmd_op, cmd_sc, accumulator_output_instr, sc_global)
		&& (cmd_acc < diag_lo || cmd_acc > diag_hi) |=> global_reg == $past(cmd_acc) && $stable(diag_mode))
		else $error("global register not loaded");

	// the main paths that a run should reach at least once
	c_type3_grant: cover property (type3_irq_req ##1 type3_irq_grant);
	c_parity_irq: cover property (parity_err_det ##1 parity_irq);
	c_skip_taken: cover property (exec ##1 skip_next);
	c_diag_mode: cover property ($rose(diag_mode));
	c_protect_on: cover property ($rose(mem_protect_en));
endmodule
`default_nettype wire

//--- tb/sc_ctrl_test.sv
/*
  self-checking bench for the low select code control block: instructions are written as command words
  over AHB-Lite and the effects are judged at the output pins and in the status and global registers.
  assumes hready is fed back from hreadyout, one clock hclk at 20 MHz and an active low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module sc_ctrl_test;
	import sc_ctrl_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic power_fail_pin = 1'b0;
	logic type3_irq_req = 1'b0;
	logic parity_err_det = 1'b0;
	wire logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic type3_irq_grant;
	logic parity_irq;
	logic parity_even_sense;
	logic mem_protect_en;
	logic diag_mode;
	logic [2:0] diag_code;
	logic skip_next;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	logic [31:0] rd;
	// single slave, so its ready is the bus ready
	assign hready = hreadyout;
	sc_ctrl sc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .power_fail_pin(power_fail_pin), .type3_irq_req(type3_irq_req),
		.parity_err_det(parity_err_det), .type3_irq_grant(type3_irq_grant), .parity_irq(parity_irq),
		.parity_even_sense(parity_even_sense), .mem_protect_en(mem_protect_en), .diag_mode(diag_mode),
		.diag_code(diag_code), .skip_next(skip_next));
	// 50 ns period
	always #25 hclk = ~hclk;
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: run did not finish", $time);
			finish_test();
		end
	end
	// -----------------------------------------------
	// shared tasks
	// -----------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	// both tasks are entered just after a rising edge and leave on one
	task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wr ? d : 32'h00000000;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	// one instruction; skip_next stands only in the cycle after the data phase
	task automatic exec(input logic [3:0] op, input logic [2:0] sc, input logic [15:0] acc, output logic sk);
		logic [31:0] q;
		bus_op(1'b1, cmd_addr, {acc, 5'h00, sc, 4'h0, op}, q);
		#1;
		sk = skip_next;
		@(posedge hclk);
	endtask
	task automatic skip_test(input logic [3:0] op, input logic [2:0] sc, input logic exp);
		logic sk;
		exec(op, sc, 16'h0000, sk);
		check(32'(sk), 32'(exp), "skip pulse");
		bus_op(1'b0, status_addr, 32'h0, rd);
		check(32'(rd[st_skip]), 32'(exp), "skip status");
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// -----------------------------------------------
	// scenarios
	// -----------------------------------------------
	task automatic t_reset();
		check({21'h0, hreadyout, hresp, mem_protect_en, diag_mode, parity_even_sense, type3_irq_grant, parity_irq,
			skip_next, diag_code}, 32'h00000400, "reset pins");
		bus_op(1'b0, status_addr, 32'h0, rd);
		check(rd, 32'h00000200, "reset status");
		bus_op(1'b0, 8'h0c, 32'h0, rd);
		check(rd, 32'h00000000, "unmapped read");
		$display("test reset done");
	endtask
	task automatic t_type3();
		logic sk;
		type3_irq_req <= 1'b1;
		skip_test(skip_if_flag_set_instr, sc_type3, 1'b0);
		skip_test(skip_if_flag_clear_instr, sc_type3, 1'b1);
		check(32'(type3_irq_grant), 32'h0, "grant off");
		exec(set_flag_instr, sc_type3, 16'h0000, sk);
		check(32'(type3_irq_grant), 32'h1, "grant on");
		skip_test(skip_if_flag_set_instr, sc_type3, 1'b1);
		skip_test(skip_if_flag_clear_instr, sc_type3, 1'b0);
		exec(clear_flag_instr, sc_type3, 16'h0000, sk);
		check(32'(type3_irq_grant), 32'h0, "grant dropped");
		type3_irq_req <= 1'b0;
		$display("test type3 done");
	endtask
	task automatic t_parity();
		logic sk;
		parity_err_det <= 1'b1;
		exec(set_control_instr, sc_parity, 16'h0000, sk);
		check(32'(parity_irq), 32'h1, "parity irq on");
		exec(clear_control_instr, sc_parity, 16'h0000, sk);
		check(32'(parity_irq), 32'h0, "parity irq off");
		exec(set_flag_instr, sc_parity, 16'h0000, sk);
		check(32'(parity_even_sense), 32'h1, "even sense");
		skip_test(skip_if_flag_set_instr, sc_parity, 1'b1);
		skip_test(skip_if_flag_clear_instr, sc_parity, 1'b0);
		exec(clear_flag_instr, sc_parity, 16'h0000, sk);
		check(32'(parity_even_sense), 32'h0, "odd sense");
		skip_test(skip_if_flag_set_instr, sc_parity, 1'b0);
		skip_test(skip_if_flag_clear_instr, sc_parity, 1'b1);
		parity_err_det <= 1'b0;
		$display("test parity done");
	endtask
	task automatic t_power();
		skip_test(skip_if_flag_set_instr, sc_power, 1'b1);
		skip_test(skip_if_flag_clear_instr, sc_power, 1'b0);
		power_fail_pin <= 1'b1;
		// let the level through the synchroniser
		repeat (4) @(posedge hclk);
		skip_test(skip_if_flag_set_instr, sc_power, 1'b0);
		skip_test(skip_if_flag_clear_instr, sc_power, 1'b1);
		power_fail_pin <= 1'b0;
		repeat (4) @(posedge hclk);
		$display("test power done");
	endtask
	task automatic t_protect();
		logic sk;
		exec(clear_control_instr, sc_protect, 16'h0000, sk);
		check(32'(mem_protect_en), 32'h0, "protect stays off");
		exec(set_control_instr, sc_protect, 16'h0000, sk);
		check(32'(mem_protect_en), 32'h1, "protect on");
		exec(clear_control_instr, sc_protect, 16'h0000, sk);
		check(32'(mem_protect_en), 32'h1, "protect kept");
		// the last skip result was taken, so a test at a code with no flag must clear it
		skip_test(skip_if_flag_set_instr, sc_protect, 1'b0);
		$display("test protect done");
	endtask
	task automatic t_diag();
		logic sk;
		exec(accumulator_output_instr, sc_global, 16'h0008, sk);
		bus_op(1'b0, global_addr, 32'h0, rd);
		check(rd, 32'h00000008, "load eight");
		check(32'(diag_mode), 32'h0, "no diagnose at eight");
		exec(accumulator_output_instr, sc_global, 16'h0101, sk);
		bus_op(1'b0, global_addr, 32'h0, rd);
		check(rd, 32'h00000101, "wide value loads");
		check(32'(diag_mode), 32'h0, "no diagnose at wide value");
		exec(accumulator_output_instr, sc_global, 16'h0007, sk);
		bus_op(1'b0, global_addr, 32'h0, rd);
		check(rd, 32'h00000101, "diag seven keeps global");
		check(32'({diag_mode, diag_code}), 32'h0000000f, "diag seven");
		// protect on, diagnose code seven, power good, last skip not taken
		bus_op(1'b0, status_addr, 32'h0, rd);
		check(rd, 32'h000002f8, "status in diagnose");
		// zero lies outside the diagnose range, so it loads while the mode stays on
		exec(accumulator_output_instr, sc_global, 16'h0000, sk);
		bus_op(1'b0, global_addr, 32'h0, rd);
		check(rd, 32'h00000000, "load zero");
		check(32'(diag_mode), 32'h1, "diagnose held");
		exec(clear_control_instr, sc_type3, 16'h0000, sk);
		check(32'({diag_mode, mem_protect_en}), 32'h0, "block reset");
		exec(accumulator_output_instr, sc_global, 16'h0001, sk);
		check(32'({diag_mode, diag_code}), 32'h00000009, "diag one");
		$display("test diag done");
	endtask
	// -----------------------------------------------
	// main sequence
	// -----------------------------------------------
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_type3();
		t_parity();
		t_power();
		t_protect();
		t_diag();
		finish_test();
	end
endmodule
`default_nettype wire
